/* File: common/tcb_pkg.sv */
// shared constants and carrier types of the 8/16-bit timer/counter
// assumes one system clock; every register access is a one-cycle strobe
package tcb_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int PRE_W = 15;
  localparam int BYTE_W = 8;
  localparam int RATE_W = 4;
  localparam int POST_W = 4;
  localparam int CS_W = 3;

  // ----------------------------------------
  // reset values and limits
  // ----------------------------------------
  localparam logic [7:0] LOW_RESET = 8'h00;
  localparam logic [7:0] HIGH_RESET = 8'hFF;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [3:0] NIBBLE_ONE = 4'h1;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  // instruction cycle is the system clock divided by four
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  localparam logic [1:0] QUARTER_ONE = 2'h1;

  // ----------------------------------------
  // clock source field codes
  // ----------------------------------------
  localparam logic [2:0] CS_PIN_TRUE = 3'h0;
  localparam logic [2:0] CS_PIN_INV = 3'h1;
  localparam logic [2:0] CS_INSTR = 3'h2;
  localparam logic [2:0] CS_HFOSC = 3'h3;
  localparam logic [2:0] CS_LFOSC = 3'h4;
  localparam logic [2:0] CS_RESVD = 3'h5;
  localparam logic [2:0] CS_SOSC = 3'h6;
  localparam logic [2:0] CS_LOGIC = 3'h7;

  // first control register fields
  typedef struct packed {
    logic timer_run_enable;
    logic wide_mode_select;
    logic [3:0] postscale_ratio_field;
  } tcb_ctrl0_s;

  // second control register fields
  typedef struct packed {
    logic [2:0] clock_source_field;
    logic async_input_select;
    logic [3:0] prescale_rate_field;
  } tcb_ctrl1_s;

  // count byte access strobes with write data
  typedef struct packed {
    logic low_wr;
    logic high_wr;
    logic low_rd;
    logic [7:0] wdata;
  } tcb_cpu_s;

endpackage

/* File: logic/tcb_prescaler.sv */
// power-of-two prescaler between the selected clock edge and the counter
// assumes edge pulses are one cycle wide and synchronous to clk
`timescale 1ns/10ps
module tcb_prescaler #(
  parameter int WIDTH = 15
) (
  input logic clk,
  input logic rst,
  input logic clear,
  input logic edge_pulse,
  input logic [3:0] rate,
  output logic tick
);
  import tcb_pkg::*;

  logic [WIDTH-1:0] count_reg, count_next;
  logic tick_reg, tick_next;
  logic [WIDTH-1:0] mask;

  // ----------------------------------------
  // divider
  // ----------------------------------------
  // mask of rate ones; rate zero bypasses, so every edge ticks
  always_comb begin
    mask = WIDTH'((32'h0000_0001 << rate) - 32'h0000_0001);
    count_next = count_reg;
    tick_next = 1'b0;
    if (clear) begin
      count_next = '0;
    end else if (edge_pulse) begin
      if ((count_reg & mask) == mask) begin
        tick_next = 1'b1;
        count_next = '0;
      end else begin
        count_next = count_reg + WIDTH'(1);
      end
    end
  end

  // registers only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_bypass_tick;
    @(posedge clk) disable iff (rst) (rate == NIBBLE_ZERO && edge_pulse && !clear) |=> tick;
  endproperty
  a_bypass_tick: assert property (p_bypass_tick) else $error("bypassed prescaler missed an edge");

  property p_clear_count;
    @(posedge clk) disable iff (rst) clear |=> (count_reg == '0 && !tick);
  endproperty
  a_clear_count: assert property (p_clear_count) else $error("prescaler not cleared");

  property p_ratio_two;
    @(posedge clk) disable iff (rst) (rate == NIBBLE_ONE && tick) |-> $past(count_reg) == WIDTH'(1);
  endproperty
  a_ratio_two: assert property (p_ratio_two) else $error("divide by two ticked early");

endmodule

/* File: logic/tcb_timer.sv */
// 8/16-bit timer/counter with prescaler, postscaler and buffered high byte
// assumes all source levels and strobes are synchronous to SYS_CLK
//
// Overview of operation
// - width select bit picks 8 or 16 bits
// - internal source counts every instruction cycle
// - external source counts its rising edges
// - 15-bit prescaler feeds the counter
// - wide low read copies true high byte
// - wide low write loads true high byte
// - 8-bit low byte compared against period
// - match drives timer output event
// - match clears low, reloads period buffer
// - 8-bit bytes read and written directly
// - reset clears low, high all ones
// - low byte writes, control writes and reset clear both scalers
// - bypassed prescaler counts each input edge
// - nonzero prescale slows timer rate
// - async mode counts on during sleep
// - sync mode aligned to instruction cycle
// - three-bit field selects clock source
// - event on 8-bit match or overflow
// - sixteen power-of-two prescale ratios
// - flag set every N+1 events
// - output toggles on postscaled event
// - enable bit runs or stops block
`timescale 1ns/10ps
module tcb_timer #(
  parameter int PRE_WIDTH = tcb_pkg::PRE_W
) (
  input logic SYS_CLK,
  input logic SYS_RST,
  input logic CTRL0_WR,
  input tcb_pkg::tcb_ctrl0_s CTRL0_WDATA,
  input logic CTRL1_WR,
  input tcb_pkg::tcb_ctrl1_s CTRL1_WDATA,
  input tcb_pkg::tcb_cpu_s CPU_ACC,
  input logic SRC_PIN,
  input logic SRC_HFOSC,
  input logic SRC_LFOSC,
  input logic SRC_SOSC,
  input logic SRC_LOGIC,
  input logic SLEEP,
  input logic FLAG_CLR,
  output logic [7:0] LOW_RDATA,
  output logic [7:0] HIGH_RDATA,
  output logic [7:0] CTRL0_RDATA,
  output tcb_pkg::tcb_ctrl1_s CTRL1_RDATA,
  output logic MATCH_PULSE,
  output logic TIMER_OUTPUT,
  output logic TIMER_EVENT_FLAG
);
  import tcb_pkg::*;
  tcb_ctrl0_s ctrl0_reg, ctrl0_next;
  tcb_ctrl1_s ctrl1_reg, ctrl1_next;
  logic [1:0] quarter_reg, quarter_next;
  logic src_prev_reg, src_prev_next;
  logic pend_reg, pend_next;
  logic [7:0] low_reg, low_next;
  logic [7:0] true_high_reg, true_high_next;
  logic [7:0] hbuf_reg, hbuf_next;
  logic [7:0] period_reg, period_next;
  logic [3:0] post_reg, post_next;
  logic out_reg, out_next;
  logic flag_reg, flag_next;
  logic match_reg, match_next;
  logic quarter_en, src_level, src_rise, scaler_clr, pre_tick;
  logic count_tick, wide, run, event_hit, post_tick;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // plain holding registers; reset leaves the block stopped in 8-bit mode
  always_comb begin
    ctrl0_next = ctrl0_reg;
    ctrl1_next = ctrl1_reg;
    if (CTRL0_WR) begin
      ctrl0_next = CTRL0_WDATA;
    end
    if (CTRL1_WR) begin
      ctrl1_next = CTRL1_WDATA;
    end
  end
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl0_reg <= '0;
      ctrl1_reg <= '0;
    end else begin
      ctrl0_reg <= ctrl0_next;
      ctrl1_reg <= ctrl1_next;
    end
  end
  assign wide = ctrl0_reg.wide_mode_select;
  assign run = ctrl0_reg.timer_run_enable;
  assign scaler_clr = CPU_ACC.low_wr | CTRL0_WR | CTRL1_WR;

  // ----------------------------------------
  // clock source selection
  // ----------------------------------------
  // instruction cycle divider runs free so sync alignment always has a beat
  always_comb quarter_next = quarter_reg + QUARTER_ONE;
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      quarter_reg <= '0;
    end else begin
      quarter_reg <= quarter_next;
    end
  end
  assign quarter_en = (quarter_reg == QUARTER_LAST);
  // source mux, reserved code stays low
  always_comb begin
    unique case (ctrl1_reg.clock_source_field)
      CS_PIN_TRUE: src_level = SRC_PIN;
      CS_PIN_INV: src_level = ~SRC_PIN;
      CS_INSTR: src_level = quarter_reg[1];
      CS_HFOSC: src_level = SRC_HFOSC;
      CS_LFOSC: src_level = SRC_LFOSC;
      CS_RESVD: src_level = 1'b0;
      CS_SOSC: src_level = SRC_SOSC;
      CS_LOGIC: src_level = SRC_LOGIC;
    endcase
  end
  // rising edges of the chosen source, only while running
  always_comb begin
    src_prev_next = src_level;
    src_rise = run & src_level & ~src_prev_reg;
  end
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_prev_next;
    end
  end
  tcb_prescaler #(
    .WIDTH(PRE_WIDTH)
  ) u_prescaler (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .clear(scaler_clr),
    .edge_pulse(src_rise),
    .rate(ctrl1_reg.prescale_rate_field),
    .tick(pre_tick)
  );

  // ----------------------------------------
  // sync or async counter clock
  // ----------------------------------------
  // sync mode holds the tick until the instruction beat; new tick wins
  always_comb begin
    pend_next = pend_reg;
    if (quarter_en && !SLEEP) begin
      pend_next = 1'b0;
    end
    if (pre_tick && !ctrl1_reg.async_input_select) begin
      pend_next = 1'b1;
    end
    if (!run || scaler_clr) begin
      pend_next = 1'b0;
    end
  end
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
    end
  end
  // async keeps counting in sleep; sync halts there
  assign count_tick = run & (ctrl1_reg.async_input_select ? pre_tick : (pend_reg & quarter_en & ~SLEEP));
  // match in 8-bit mode, rollover in 16-bit; a low write wins the cycle
  assign event_hit = count_tick & ~CPU_ACC.low_wr &
                     (wide ? ({true_high_reg, low_reg} == {BYTE_ONES, BYTE_ONES}) : (low_reg == period_reg));

  // ----------------------------------------
  // count registers
  // ----------------------------------------
  // write strobes take priority over a tick in the same cycle
  always_comb begin
    low_next = low_reg;
    true_high_next = true_high_reg;
    hbuf_next = hbuf_reg;
    period_next = period_reg;
    if (count_tick) begin
      if (wide) begin
        {true_high_next, low_next} = {true_high_reg, low_reg} + {LOW_RESET, BYTE_ONE};
      end else if (event_hit) begin
        low_next = LOW_RESET;
        period_next = hbuf_reg;
      end else begin
        low_next = low_reg + BYTE_ONE;
      end
    end
    // atomic read latches true high byte
    if (CPU_ACC.low_rd && wide) begin
      hbuf_next = true_high_reg;
    end
    if (CPU_ACC.high_wr) begin
      hbuf_next = CPU_ACC.wdata;
    end
    if (CPU_ACC.low_wr) begin
      low_next = CPU_ACC.wdata;
      // atomic write moves buffered high byte
      if (wide) begin
        true_high_next = hbuf_reg;
      end
    end
  end

  // reset values of the count bytes
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      low_reg <= LOW_RESET;
      true_high_reg <= LOW_RESET;
      hbuf_reg <= HIGH_RESET;
      period_reg <= HIGH_RESET;
    end else begin
      low_reg <= low_next;
      true_high_reg <= true_high_next;
      hbuf_reg <= hbuf_next;
      period_reg <= period_next;
    end
  end

  // ----------------------------------------
  // postscaler, output and flag
  // ----------------------------------------
  // one postscaled event every N+1 hits
  assign post_tick = event_hit & (post_reg == ctrl0_reg.postscale_ratio_field);
  always_comb begin
    post_next = post_reg;
    out_next = out_reg;
    flag_next = flag_reg;
    match_next = event_hit;
    if (event_hit) begin
      post_next = post_tick ? NIBBLE_ZERO : post_reg + NIBBLE_ONE;
    end
    if (scaler_clr) begin
      post_next = NIBBLE_ZERO;
    end
    if (post_tick) begin
      out_next = ~out_reg;
    end
    // flag clear loses to a simultaneous set
    if (FLAG_CLR) begin
      flag_next = 1'b0;
    end
    if (post_tick) begin
      flag_next = 1'b1;
    end
  end
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      post_reg <= NIBBLE_ZERO;
      out_reg <= 1'b0;
      flag_reg <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      post_reg <= post_next;
      out_reg <= out_next;
      flag_reg <= flag_next;
      match_reg <= match_next;
    end
  end
  // match shown on the output path
  assign TIMER_OUTPUT = out_reg;
  assign MATCH_PULSE = match_reg;
  assign TIMER_EVENT_FLAG = flag_reg;
  assign LOW_RDATA = low_reg;
  assign HIGH_RDATA = hbuf_reg;
  assign CTRL0_RDATA = {ctrl0_reg.timer_run_enable, 1'b0, out_reg, ctrl0_reg.wide_mode_select,
                        ctrl0_reg.postscale_ratio_field};
  assign CTRL1_RDATA = ctrl1_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_wide_read;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CPU_ACC.low_rd && wide && !CPU_ACC.high_wr) |=> hbuf_reg == $past(true_high_reg);
  endproperty
  a_wide_read: assert property (p_wide_read) else $error("high buffer not latched on read");
  property p_wide_write;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CPU_ACC.low_wr && wide) |=> (true_high_reg == $past(hbuf_reg) && low_reg == $past(CPU_ACC.wdata));
  endproperty
  a_wide_write: assert property (p_wide_write) else $error("16-bit write not atomic");
  property p_match_reload;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (event_hit && !wide) |=> (low_reg == LOW_RESET && period_reg == $past(hbuf_reg));
  endproperty
  a_match_reload: assert property (p_match_reload) else $error("match did not clear and reload");
  property p_rollover;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (count_tick && wide && !CPU_ACC.low_wr && {true_high_reg, low_reg} == 16'hFFFF) |=> match_reg;
  endproperty
  a_rollover: assert property (p_rollover) else $error("rollover raised no event");
  property p_sync_beat;
    @(posedge SYS_CLK) disable iff (SYS_RST) (count_tick && !ctrl1_reg.async_input_select) |-> quarter_en;
  endproperty
  a_sync_beat: assert property (p_sync_beat) else $error("sync count off the instruction beat");
  property p_sleep_halt;
    @(posedge SYS_CLK) disable iff (SYS_RST) (SLEEP && !ctrl1_reg.async_input_select) |-> !count_tick;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("sync counter ran in sleep");
  property p_idle_still;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (!run && !CPU_ACC.low_wr && !CTRL0_WR) |=> (low_reg == $past(low_reg) && out_reg == $past(out_reg));
  endproperty
  a_idle_still: assert property (p_idle_still) else $error("disabled timer moved");
  property p_post_ratio;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      post_tick |=> (flag_reg && out_reg != $past(out_reg) && post_reg == NIBBLE_ZERO);
  endproperty
  a_post_ratio: assert property (p_post_ratio) else $error("postscaled event not applied");
  property p_flag_hold;
    @(posedge SYS_CLK) disable iff (SYS_RST) (flag_reg && !FLAG_CLR) |=> flag_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("event flag dropped by itself");
  c_match8: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) event_hit && !wide);
  c_roll16: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) event_hit && wide);
  c_post_div: cover property (@(posedge SYS_CLK) disable iff (SYS_RST)
    post_tick && ctrl0_reg.postscale_ratio_field != NIBBLE_ZERO);

endmodule

/* File: verif/tcb_src_model.sv */
// far-side count source for the timer/counter bench: one level drives only the selected source input
// assumes the bench calls pulse() from one process at a time, clocked by the system clock
`timescale 1ns/10ps
module tcb_src_model (
  input wire logic clk,
  input wire logic [2:0] sel,
  output logic src_pin,
  output logic src_hfosc,
  output logic src_lfosc,
  output logic src_sosc,
  output logic src_logic
);
  import tcb_pkg::*;

  logic lvl_reg;

  initial lvl_reg = 1'b0;

  // only the selected source moves, so a source mux wired to the wrong input loses the edges
  assign src_pin = lvl_reg & ((sel == CS_PIN_TRUE) | (sel == CS_PIN_INV));
  assign src_hfosc = lvl_reg & (sel == CS_HFOSC);
  assign src_lfosc = lvl_reg & (sel == CS_LFOSC);
  assign src_sosc = lvl_reg & (sel == CS_SOSC);
  assign src_logic = lvl_reg & (sel == CS_LOGIC);

  // three cycles high and three low: slower than the instruction cycle so sync mode never merges edges
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      lvl_reg <= 1'b1;
      repeat (3) @(posedge clk);
      lvl_reg <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

/* File: verif/tcb_timer_tb_top.sv */
// self-checking bench of the 8/16-bit timer/counter: strobed accesses and counted source edges
// assumes the design's register ports and the source model; outputs are read one tick after edges
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tcb_timer_tb_top;
  import tcb_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic sys_clk;
  logic sys_rst;
  logic ctrl0_wr;
  tcb_ctrl0_s ctrl0_wdata;
  logic ctrl1_wr;
  tcb_ctrl1_s ctrl1_wdata;
  tcb_cpu_s cpu_acc;
  logic sleep;
  logic flag_clr;
  logic [2:0] src_sel;
  logic src_pin, src_hfosc, src_lfosc, src_sosc, src_logic;
  logic [7:0] low_rdata, high_rdata, ctrl0_rdata, snap;
  tcb_ctrl1_s ctrl1_rdata;
  logic match_pulse, timer_output, flag;
  int miscompares = 0;
  int checks_done = 0;
  int match_cnt = 0;

  // free-running 250 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  tcb_timer tcb_timer_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .CTRL0_WR(ctrl0_wr),
    .CTRL0_WDATA(ctrl0_wdata), .CTRL1_WR(ctrl1_wr), .CTRL1_WDATA(ctrl1_wdata), .CPU_ACC(cpu_acc),
    .SRC_PIN(src_pin), .SRC_HFOSC(src_hfosc), .SRC_LFOSC(src_lfosc), .SRC_SOSC(src_sosc),
    .SRC_LOGIC(src_logic), .SLEEP(sleep), .FLAG_CLR(flag_clr), .LOW_RDATA(low_rdata),
    .HIGH_RDATA(high_rdata), .CTRL0_RDATA(ctrl0_rdata), .CTRL1_RDATA(ctrl1_rdata),
    .MATCH_PULSE(match_pulse), .TIMER_OUTPUT(timer_output), .TIMER_EVENT_FLAG(flag));

  tcb_src_model tcb_src_model_inst (.clk(sys_clk), .sel(src_sel), .src_pin(src_pin), .src_hfosc(src_hfosc),
    .src_lfosc(src_lfosc), .src_sosc(src_sosc), .src_logic(src_logic));

  // count match pulses per cycle; a pulse stuck high shows up as a surplus
  always @(posedge sys_clk) begin
    if (match_pulse === 1'b1) match_cnt <= match_cnt + 1;
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr0(input logic run, input logic wide, input logic [3:0] post);
    @(posedge sys_clk);
    ctrl0_wr <= 1'b1;
    ctrl0_wdata <= {run, wide, post};
    @(posedge sys_clk);
    ctrl0_wr <= 1'b0;
  endtask

  task automatic wr1(input logic [2:0] cs, input logic async, input logic [3:0] rate);
    @(posedge sys_clk);
    ctrl1_wr <= 1'b1;
    ctrl1_wdata <= {cs, async, rate};
    @(posedge sys_clk);
    ctrl1_wr <= 1'b0;
  endtask

  // one-cycle count byte strobe: low write, high write, low read
  task automatic acc(input logic lw, input logic hw, input logic lr, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_acc <= {lw, hw, lr, d};
    @(posedge sys_clk);
    cpu_acc <= '0;
  endtask

  task automatic set_sleep(input logic v);
    @(posedge sys_clk);
    sleep <= v;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // whole run is under a thousand cycles; this span leaves a wide margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    ctrl0_wr = 1'b0;
    ctrl0_wdata = '0;
    ctrl1_wr = 1'b0;
    ctrl1_wdata = '0;
    cpu_acc = '0;
    sleep = 1'b0;
    flag_clr = 1'b0;
    src_sel = CS_PIN_TRUE;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    idle(1);
    `CHK(low_rdata, LOW_RESET)
    `CHK(high_rdata, HIGH_RESET)
    `CHK(ctrl0_rdata, 8'h00)
    `CHK(ctrl1_rdata, 8'h00)
    `CHK(flag, 1'b0)
    $display("test reset done");
    // 8-bit period: first match at ff loads period 02 from the high register
    wr1(CS_PIN_TRUE, 1'b1, 4'h0);
    wr0(1'b1, 1'b0, 4'h0);
    acc(1'b0, 1'b1, 1'b0, 8'h02);
    acc(1'b1, 1'b0, 1'b0, 8'hFF);
    idle(1);
    `CHK(high_rdata, 8'h02)
    `CHK(ctrl1_rdata, 8'h10)
    `CHK(low_rdata, 8'hFF)
    tcb_src_model_inst.pulse(1);
    idle(2);
    `CHK(low_rdata, 8'h00)
    `CHK(match_cnt, 1)
    `CHK(flag, 1'b1)
    `CHK(ctrl0_rdata, 8'hA0)
    tcb_src_model_inst.pulse(2);
    idle(2);
    `CHK(low_rdata, 8'h02)
    `CHK(match_cnt, 1)
    tcb_src_model_inst.pulse(1);
    idle(2);
    `CHK(low_rdata, 8'h00)
    `CHK(match_cnt, 2)
    `CHK(timer_output, 1'b0)
    $display("test period done");
    // postscale 1:2 then a disabled stretch
    wr0(1'b1, 1'b0, 4'h1);
    @(posedge sys_clk);
    flag_clr <= 1'b1;
    @(posedge sys_clk);
    flag_clr <= 1'b0;
    tcb_src_model_inst.pulse(3);
    idle(2);
    `CHK(flag, 1'b0)
    `CHK(match_cnt, 3)
    tcb_src_model_inst.pulse(3);
    idle(2);
    `CHK(flag, 1'b1)
    `CHK(timer_output, 1'b1)
    wr0(1'b0, 1'b0, 4'h0);
    tcb_src_model_inst.pulse(2);
    idle(6);
    `CHK(low_rdata, 8'h00)
    `CHK(match_cnt, 4)
    $display("test postscale done");
    // 16-bit buffered access and rollover
    wr0(1'b1, 1'b1, 4'h0);
    acc(1'b0, 1'b1, 1'b0, 8'h12);
    acc(1'b1, 1'b0, 1'b0, 8'h34);
    idle(1);
    `CHK(low_rdata, 8'h34)
    tcb_src_model_inst.pulse(1);
    acc(1'b0, 1'b0, 1'b1, 8'h00);
    idle(1);
    `CHK(low_rdata, 8'h35)
    `CHK(high_rdata, 8'h12)
    acc(1'b0, 1'b1, 1'b0, 8'hFF);
    acc(1'b1, 1'b0, 1'b0, 8'hFF);
    tcb_src_model_inst.pulse(1);
    acc(1'b0, 1'b0, 1'b1, 8'h00);
    idle(1);
    `CHK(low_rdata, 8'h00)
    `CHK(high_rdata, 8'h00)
    `CHK(match_cnt, 5)
    $display("test wide done");
    // prescale boundary: one edge short of two counts, then the second count
    for (int r = 0; r < 5; r++) begin
      wr1(CS_PIN_TRUE, 1'b1, 4'(r));
      acc(1'b1, 1'b0, 1'b0, 8'h00);
      tcb_src_model_inst.pulse((2 << r) - 1);
      idle(2);
      `CHK(low_rdata, 8'h01)
      tcb_src_model_inst.pulse(1);
      idle(2);
      `CHK(low_rdata, 8'h02)
    end
    $display("test prescale done");
    // every external source code; the reserved code has no clock
    for (int c = 0; c < 8; c++) begin
      if (c != 2) begin
        src_sel <= 3'(c);
        wr1(3'(c), 1'b1, 4'h0);
        idle(4);
        acc(1'b1, 1'b0, 1'b0, 8'h00);
        tcb_src_model_inst.pulse(2);
        idle(2);
        `CHK(low_rdata, (c == 5) ? 8'h00 : 8'h02)
      end
    end
    src_sel <= CS_PIN_TRUE;
    $display("test sources done");
    // internal source: one count per four system clocks, halved by prescale 1:2
    for (int r = 0; r < 2; r++) begin
      wr1(CS_INSTR, 1'b1, 4'(r));
      idle(8);
      snap = low_rdata;
      idle(40);
      `CHK(8'(low_rdata - snap), 8'(10 >> r))
    end
    $display("test internal done");
    // sync mode halts in sleep and keeps its pending tick; async counts on
    wr1(CS_PIN_TRUE, 1'b0, 4'h0);
    idle(4);
    acc(1'b1, 1'b0, 1'b0, 8'h00);
    set_sleep(1'b1);
    tcb_src_model_inst.pulse(1);
    idle(6);
    `CHK(low_rdata, 8'h00)
    set_sleep(1'b0);
    idle(6);
    `CHK(low_rdata, 8'h01)
    tcb_src_model_inst.pulse(4);
    idle(6);
    `CHK(low_rdata, 8'h05)
    wr1(CS_PIN_TRUE, 1'b1, 4'h0);
    set_sleep(1'b1);
    tcb_src_model_inst.pulse(2);
    idle(2);
    `CHK(low_rdata, 8'h07)
    set_sleep(1'b0);
    $display("test sleep done");
    // mid-run reset: count bytes, first control register and flag go back to their reset values
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    idle(1);
    `CHK(low_rdata, LOW_RESET)
    `CHK(high_rdata, HIGH_RESET)
    `CHK(ctrl0_rdata, 8'h00)
    `CHK(flag, 1'b0)
    $display("test reset again done");
    tally_and_finish();
  end
endmodule
